// *** src/dma_activation.sv ***
// Activation, request sensing and bus acquisition of a four-channel DMA engine
// Operation
// RQ1 - Starts come from on-chip interrupts, request pins or auto-request, per mode.
// RQ2 - Timers start short channels and full block; serial n serves only its group.
// RQ3 - Pins only for B short or full; block edge only; auto only full normal.
// RQ4 - A claimed interrupt is withheld from the CPU while the channel is enabled.
// RQ5 - Starting from an interrupt clears the peripheral interrupt flag.
// RQ6 - Shared interrupt: highest channel clears flag, others stay pending in order.
// RQ7 - Pin source forces request pin input and transfer-end pin output.
// RQ8 - Edge sensing moves exactly one unit per detected falling edge.
// RQ9 - Requester must not give a new edge before the unit completes.
// RQ10 - Level sensing keeps going while low, releasing the bus per unit.
// RQ11 - Level high pauses after the unit; a low is held until one unit moves.
// RQ12 - Transfer-end goes low in the final write of short and normal modes.
// RQ13 - Block mode takes edges only; each edge moves a block, end low per block.
// RQ14 - Auto-request starts once enabled and runs to completion.
// RQ15 - Cycle-steal gives the bus up after every unit.
// RQ16 - Burst keeps the bus; higher request frees it after the current unit.
// RQ17 - One dead state after bus grant before read then write.
// RQ18 - Read and write pair is never split; bus controller paces each cycle.
// RQ19 - At least four states from pin request to start; pin ignored meanwhile.
// RQ20 - Pin sampling resumes at read end, or block end in block mode.
// RQ21 - Priority is channel 0 down to 3, A above B; full uses the A slot.
// RQ22 - Channels 0-1 and 2-3 are two bus masters with own bus requests.
// RQ23 - Normal mode counts down per unit; zero clears enable and stops.
// RQ24 - Request pins pass two flip-flops before detection.
// RQ25 - At grant the highest-priority pending channel of the group starts.
`timescale 1ns/10ps
module dma_activation
  import dma_act_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer0_match_irq,
  input wire logic timer1_match_irq,
  input wire logic timer2_match_irq,
  input wire logic timer3_match_irq,
  input wire logic serial0_tx_empty_irq,
  input wire logic serial0_rx_full_irq,
  input wire logic serial1_tx_empty_irq,
  input wire logic serial1_rx_full_irq,
  output logic [7:0] cpu_irq,
  output logic [7:0] irq_flag_clear,
  input wire logic [3:0] ext_transfer_request_n,
  output logic [3:0] transfer_end_n,
  output logic [3:0] request_pin_input,
  output logic [3:0] end_pin_output,
  output logic [1:0] bus_request,
  input wire logic [1:0] bus_grant,
  input wire logic [1:0] other_master_request,
  input wire logic [1:0] bus_cycle_done,
  output logic [1:0] dma_read,
  output logic [1:0] dma_write,
  output logic [2:0] active_channel0,
  output logic [2:0] active_channel1
);

  logic [11:0] ctrl_q [NUM_CH];
  logic [11:0] ctrl_d [NUM_CH];
  logic [15:0] count_q [NUM_SUB];
  logic [15:0] count_d [NUM_SUB];
  logic [7:0] bsize_q [NUM_CH];
  logic [7:0] bsize_d [NUM_CH];
  logic [7:0] bcnt_q [NUM_CH];
  logic [7:0] bcnt_d [NUM_CH];
  logic [NUM_SUB-1:0] pend_q;
  logic [NUM_SUB-1:0] pend_d;
  logic [NUM_CH-1:0] armed_q;
  logic [NUM_CH-1:0] armed_d;
  logic [NUM_CH-1:0] transfer_end_n_n_q;
  logic [NUM_CH-1:0] transfer_end_n_n_d;
  logic [NUM_CH-1:0] pin_in_q;
  logic [NUM_CH-1:0] pin_in_d;
  logic [NUM_CH-1:0] req_hit;
  state_type state_q [NUM_GRP];
  state_type state_d [NUM_GRP];
  logic [1:0] sel_q [NUM_GRP];
  logic [1:0] sel_d [NUM_GRP];
  logic [2:0] dly_q [NUM_GRP];
  logic [2:0] dly_d [NUM_GRP];
  logic [2:0] active_q [NUM_GRP];
  logic [2:0] active_d [NUM_GRP];
  logic [1:0] bus_req_q;
  logic [1:0] bus_req_d;
  logic [1:0] rd_q;
  logic [1:0] rd_d;
  logic [1:0] wr_q;
  logic [1:0] wr_d;
  logic [7:0] irq_vec;
  logic [7:0] irq_prev_q;
  logic [7:0] cpu_irq_q;
  logic [7:0] cpu_irq_d;
  logic [7:0] irq_clr_q;
  logic [7:0] irq_clr_d;
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_fire;

  // Source of sub-channel A or B from its control word
  function automatic logic [2:0] sub_src(input logic [11:0] ctl, input logic b);
    sub_src = b ? ctl[CTL_SRC_B_LSB +: SRC_W] : ctl[CTL_SRC_A_LSB +: SRC_W];
  endfunction

  // Whether a source may start this sub-channel in its mode
  function automatic logic allowed(input logic [11:0] ctl, input logic b, input logic [2:0] src);
    logic full;
    logic blk;
    full = ctl[CTL_FULL];
    blk = ctl[CTL_BLOCK];
    if (full && b)
      allowed = 1'b0; // B half is absorbed into the pair in full address mode
    else if (src <= SRC_TIMER3)
      allowed = !full || blk; // see RQ2
    else if (src == SRC_TX || src == SRC_RX)
      allowed = !full; // see RQ2
    else if (src == SRC_EXT)
      allowed = full ? (!blk || !ctl[CTL_LEVEL]) : b; // see RQ3
    else
      allowed = full && !blk; // see RQ3
  endfunction

  // Interrupt line index; serial sources follow the channel group
  function automatic logic [2:0] irq_of(input logic [2:0] src, input logic grp);
    irq_of = (src <= SRC_TIMER3) ? src : {1'b1, grp, src[0]}; // see RQ2
  endfunction

  // Byte-lane merge of a bus write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction

  assign irq_vec = {serial1_rx_full_irq, serial1_tx_empty_irq, serial0_rx_full_irq, serial0_tx_empty_irq,
                    timer3_match_irq, timer2_match_irq, timer1_match_irq, timer0_match_irq};
  assign wr_fire = avs_write && !wait_q;

  // One request sensor per channel request pin
  for (genvar gi = 0; gi < NUM_CH; gi++)
  begin : g_sense
    req_sense u_sense (
      .clk(clk),
      .rst_n(rst_n),
      .pin_n(ext_transfer_request_n[gi]),
      .level_mode(ctrl_q[gi][CTL_LEVEL]),
      .armed(armed_q[gi]),
      .hit(req_hit[gi])
    );
  end

  // Bus slave: fixed one-cycle wait, read data captured with the answer
  always_comb
  begin
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    if (avs_read && wait_q)
    begin
      rdata_d = 32'h0000_0000;
      if (!avs_address[6])
      begin
        case (avs_address[3:0])
          OFS_CTRL: rdata_d = {20'h0_0000, ctrl_q[avs_address[5:4]]};
          OFS_COUNT_A: rdata_d = {16'h0000, count_q[{avs_address[5:4], 1'b0}]};
          OFS_COUNT_B: rdata_d = {16'h0000, count_q[{avs_address[5:4], 1'b1}]};
          OFS_BSIZE: rdata_d = {16'h0000, bcnt_q[avs_address[5:4]], bsize_q[avs_address[5:4]]};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
      else if (avs_address == OFS_STATUS)
        rdata_d = {10'h000, 3'(state_q[1]), 3'(state_q[0]), pend_q, armed_q, transfer_end_n_n_q};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Group engines, channel counters, pending requests and register writes
  always_comb
  begin
    int s;
    int c;
    int pick;
    logic [3:0] gp;
    logic [3:0] lower;
    logic [NUM_SUB-1:0] pend_clr;
    logic [NUM_CH-1:0] arm_set;
    logic [15:0] cnt_next;
    logic [2:0] src;
    logic ok;
    logic hi;
    logic hold;
    logic blk_end;
    logic fin;
    logic [7:0] claimed;
    logic set;
    s = 0;
    c = 0;
    pick = 0;
    gp = 4'h0;
    lower = 4'h0;
    pend_clr = '0;
    arm_set = '0;
    cnt_next = 16'h0000;
    src = SRC_TIMER0;
    ok = 1'b0;
    hi = 1'b0;
    hold = 1'b0;
    blk_end = 1'b0;
    fin = 1'b0;
    claimed = 8'h00;
    set = 1'b0;
    ctrl_d = ctrl_q;
    count_d = count_q;
    bsize_d = bsize_q;
    bcnt_d = bcnt_q;
    armed_d = armed_q;
    state_d = state_q;
    sel_d = sel_q;
    dly_d = dly_q;
    bus_req_d = bus_req_q;
    irq_clr_d = 8'h00;
    transfer_end_n_n_d = '1;
    pin_in_d = '0;
    // Each group is a separate bus master with its own request
    for (int g = 0; g < NUM_GRP; g++)
    begin // see RQ22
      gp = pend_q[g*4 +: 4];
      pick = 0;
      for (int l = 3; l >= 0; l--)
      begin
        if (gp[l])
          pick = l; // see RQ21
      end
      s = g * 4 + int'(sel_q[g]);
      c = s / 2;
      case (state_q[g])
        ST_IDLE:
        begin
          bus_req_d[g] = 1'b0;
          dly_d[g] = 3'h0;
          if (|gp)
          begin
            state_d[g] = ST_ARB;
            bus_req_d[g] = 1'b1;
          end
        end
        ST_ARB:
        begin
          if (!(|gp))
          begin
            state_d[g] = ST_IDLE;
            bus_req_d[g] = 1'b0;
          end
          else if (dly_q[g] < START_WAIT_CYCLES)
            dly_d[g] = dly_q[g] + 3'h1; // see RQ19
          else if (bus_grant[g])
          begin
            sel_d[g] = 2'(pick); // see RQ25
            state_d[g] = ST_DEAD; // see RQ17
            s = g * 4 + pick;
            c = s / 2;
            src = sub_src(ctrl_q[c], s[0]);
            // Shared sources: the first starter clears, later starters find it low
            if (src <= SRC_RX && irq_vec[irq_of(src, 1'(g))])
              irq_clr_d[irq_of(src, 1'(g))] = 1'b1; // see RQ5, see RQ6
          end
        end
        ST_DEAD:
          state_d[g] = ST_READ; // see RQ17
        ST_READ:
        begin
          if (bus_cycle_done[g])
          begin
            state_d[g] = ST_WRITE; // see RQ18
            if (!(ctrl_q[c][CTL_FULL] && ctrl_q[c][CTL_BLOCK]))
              {arm_set[c], pend_clr[s]} = 2'b11; // see RQ20, see RQ11
          end
        end
        ST_WRITE:
        begin
          if (bus_cycle_done[g])
          begin
            blk_end = 1'b0;
            cnt_next = count_q[s] - 16'h0001; // see RQ23
            if (ctrl_q[c][CTL_FULL] && ctrl_q[c][CTL_BLOCK])
            begin
              if (bcnt_q[c] == 8'h01)
              begin
                blk_end = 1'b1;
                bcnt_d[c] = bsize_q[c];
                count_d[s] = cnt_next;
                pend_clr[s] = 1'b1; // see RQ13
                arm_set[c] = 1'b1; // see RQ20
                if (cnt_next == 16'h0000)
                  ctrl_d[c][s % 2] = 1'b0;
              end
              else
                bcnt_d[c] = bcnt_q[c] - 8'h01;
            end
            else
            begin
              count_d[s] = cnt_next;
              if (cnt_next == 16'h0000)
                ctrl_d[c][s % 2] = 1'b0; // see RQ23
            end
            lower = 4'((4'h1 << sel_q[g]) - 4'h1);
            hi = other_master_request[g] || (g == 1 && (|pend_q[3:0])) || (|(gp & lower)); // see RQ16
            src = sub_src(ctrl_q[c], s[0]);
            hold = ctrl_q[c][CTL_FULL] && !hi && ctrl_d[c][s % 2] &&
                   ((ctrl_q[c][CTL_BLOCK] && !blk_end) ||
                    (!ctrl_q[c][CTL_BLOCK] && ctrl_q[c][CTL_BURST] && src == SRC_AUTO)); // see RQ16
            if (hold)
              state_d[g] = ST_READ;
            else
            begin
              state_d[g] = ST_IDLE; // see RQ15, see RQ10
              bus_req_d[g] = 1'b0;
            end
          end
        end
        default:
        begin
          state_d[g] = ST_IDLE;
          bus_req_d[g] = 1'b0;
        end
      endcase
      // Transfer-end low through the write of the last unit
      if (state_d[g] == ST_WRITE)
      begin
        s = g * 4 + int'(sel_d[g]);
        c = s / 2;
        if (ctrl_q[c][CTL_FULL] && ctrl_q[c][CTL_BLOCK])
          fin = bcnt_q[c] == 8'h01; // see RQ13
        else
          fin = count_q[s] == 16'h0001; // see RQ12
        transfer_end_n_n_d[c] = !fin;
      end
    end
    // Software writes land after the engine, so a write wins over a hardware update
    if (wr_fire && !avs_address[6])
    begin
      c = int'(avs_address[5:4]);
      case (avs_address[3:0])
        OFS_CTRL: ctrl_d[c] = 12'(merge({20'h0_0000, ctrl_q[c]}, avs_writedata, avs_byteenable));
        OFS_COUNT_A: count_d[c*2] = 16'(merge({16'h0000, count_q[c*2]}, avs_writedata, avs_byteenable));
        OFS_COUNT_B: count_d[c*2+1] = 16'(merge({16'h0000, count_q[c*2+1]}, avs_writedata, avs_byteenable));
        OFS_BSIZE:
        begin
          bsize_d[c] = 8'(merge({24'h00_0000, bsize_q[c]}, avs_writedata, avs_byteenable));
          bcnt_d[c] = bsize_d[c];
        end
        default: ;
      endcase
    end
    armed_d = armed_q | arm_set;
    // Request latching per sub-channel; a new request beats the unit-end clear
    for (int k = 0; k < NUM_SUB; k++)
    begin
      c = k / 2;
      src = sub_src(ctrl_d[c], k[0]);
      ok = ctrl_d[c][k % 2] && allowed(ctrl_d[c], k[0], src); // see RQ1
      case (src)
        SRC_EXT: set = req_hit[c]; // see RQ8, see RQ10
        SRC_AUTO: set = 1'b1; // see RQ14
        default: set = irq_vec[irq_of(src, 1'(c / 2))] && !irq_prev_q[irq_of(src, 1'(c / 2))]; // see RQ6
      endcase
      pend_d[k] = ok && (set || (pend_q[k] && !pend_clr[k])); // see RQ11
      // Pin ignored once taken until the engine re-arms it
      if (ok && src == SRC_EXT && req_hit[c])
        armed_d[c] = 1'b0; // see RQ19, see RQ9
      if (ok && src <= SRC_RX)
        claimed[irq_of(src, 1'(c / 2))] = 1'b1; // see RQ4
      if (src == SRC_EXT && allowed(ctrl_d[c], k[0], src))
        pin_in_d[c] = 1'b1; // see RQ7
    end
    cpu_irq_d = irq_vec & ~claimed; // see RQ4
    for (int g = 0; g < NUM_GRP; g++)
    begin
      rd_d[g] = state_d[g] == ST_READ;
      wr_d[g] = state_d[g] == ST_WRITE;
      active_d[g] = {1'(g), sel_d[g]};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        ctrl_q[i] <= CTRL_RST;
        bsize_q[i] <= BSIZE_RST;
        bcnt_q[i] <= BSIZE_RST;
      end
      for (int i = 0; i < NUM_SUB; i++)
        count_q[i] <= COUNT_RST;
      for (int i = 0; i < NUM_GRP; i++)
      begin
        state_q[i] <= ST_IDLE;
        sel_q[i] <= 2'h0;
        dly_q[i] <= 3'h0;
        active_q[i] <= 3'h0;
      end
      pend_q <= '0;
      armed_q <= '1;
      transfer_end_n_n_q <= '1;
      pin_in_q <= '0;
      bus_req_q <= 2'h0;
      rd_q <= 2'h0;
      wr_q <= 2'h0;
      irq_prev_q <= 8'h00;
      cpu_irq_q <= 8'h00;
      irq_clr_q <= 8'h00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      bsize_q <= bsize_d;
      bcnt_q <= bcnt_d;
      state_q <= state_d;
      sel_q <= sel_d;
      dly_q <= dly_d;
      active_q <= active_d;
      pend_q <= pend_d;
      armed_q <= armed_d;
      transfer_end_n_n_q <= transfer_end_n_n_d;
      pin_in_q <= pin_in_d;
      bus_req_q <= bus_req_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      irq_prev_q <= irq_vec;
      cpu_irq_q <= cpu_irq_d;
      irq_clr_q <= irq_clr_d;
    end
  end

  // Outputs straight from registers
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign cpu_irq = cpu_irq_q;
  assign irq_flag_clear = irq_clr_q;
  assign transfer_end_n = transfer_end_n_n_q;
  assign request_pin_input = pin_in_q;
  assign end_pin_output = pin_in_q;
  assign bus_request = bus_req_q;
  assign dma_read = rd_q;
  assign dma_write = wr_q;
  assign active_channel0 = active_q[0];
  assign active_channel1 = active_q[1];

endmodule

// *** src/dma_act_pkg.sv ***
// Shared constants and types of the DMA activation and priority block
package dma_act_pkg;

  // Structure
  localparam int NUM_CH = 4;
  localparam int NUM_SUB = 8;
  localparam int NUM_GRP = 2;
  localparam int NUM_IRQ = 8;

  // Register offsets inside one channel block (byte addresses)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_COUNT_A = 4'h4;
  localparam logic [3:0] OFS_COUNT_B = 4'h8;
  localparam logic [3:0] OFS_BSIZE = 4'hc;
  // Status register (byte address)
  localparam logic [6:0] OFS_STATUS = 7'h40;

  // Control register fields
  localparam int CTL_EN_A = 0;
  localparam int CTL_EN_B = 1;
  localparam int CTL_FULL = 2;
  localparam int CTL_BLOCK = 3;
  localparam int CTL_BURST = 4;
  localparam int CTL_LEVEL = 5;
  localparam int CTL_SRC_A_LSB = 6;
  localparam int CTL_SRC_B_LSB = 9;
  localparam int SRC_W = 3;
  localparam int CTL_W = 12;

  // Reset values
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] BSIZE_RST = 8'h01;

  // Activation source codes
  localparam logic [2:0] SRC_TIMER0 = 3'h0;
  localparam logic [2:0] SRC_TIMER3 = 3'h3;
  localparam logic [2:0] SRC_TX = 3'h4;
  localparam logic [2:0] SRC_RX = 3'h5;
  localparam logic [2:0] SRC_EXT = 3'h6;
  localparam logic [2:0] SRC_AUTO = 3'h7;

  // Timing: states from a pin request to the first bus state of the transfer
  localparam int CLK_PERIOD_NS = 10;
  localparam int START_STATES = 4;
  localparam int START_NS = START_STATES * CLK_PERIOD_NS;
  // The granting arbitration state and the dead state already count for two of them
  localparam logic [2:0] START_WAIT_CYCLES = 3'((START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 2);

  // Group engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB = 3'b001,
    ST_DEAD = 3'b010,
    ST_READ = 3'b011,
    ST_WRITE = 3'b100
  } state_type;

endpackage

// *** src/req_sense.sv ***
// Request pin synchroniser with edge or level detection and sampling gate
`timescale 1ns/10ps
module req_sense
  import dma_act_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_n,
  input wire logic level_mode,
  input wire logic armed,
  output logic hit
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic hit_q;
  logic hit_d;

  // Falling edge or low level, only while the pin is being sampled
  always_comb
  begin
    if (level_mode)
      hit_d = armed && !sync2_q; // see RQ10
    else
      hit_d = armed && prev_q && !sync2_q; // see RQ8
  end

  // Two-stage synchroniser; only the second stage feeds detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
      hit_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_n; // see RQ24
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      hit_q <= hit_d;
    end
  end

  assign hit = hit_q;

endmodule

// *** dv/dma_activation_asserts.sv ***
// Port checker for the DMA activation block
`timescale 1ns/10ps
module dma_activation_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [7:0] cpu_irq,
  input wire logic [7:0] irq_flag_clear,
  input wire logic [3:0] transfer_end_n,
  input wire logic [3:0] request_pin_input,
  input wire logic [3:0] end_pin_output,
  input wire logic [1:0] bus_request,
  input wire logic [1:0] bus_grant,
  input wire logic [1:0] dma_read,
  input wire logic [1:0] dma_write
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Arbitration and dead state leave four quiet states before a read
  sequence arb_quiet0;
    !dma_read[0] [*4];
  endsequence
  // A read that ends hands straight over to its write
  sequence read_end0;
    $fell(dma_read[0]);
  endsequence
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered");
  bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  start_gap_a: assert property ($rose(bus_request[0]) |-> arb_quiet0)
    else $error("read too soon after bus request");
  pair_order_a: assert property (read_end0 |-> dma_write[0])
    else $error("read not followed by write");
  hold_bus_a: assert property ((dma_read[0] || dma_write[0]) |-> bus_request[0] && bus_grant[0])
    else $error("bus dropped inside a unit");
  rw_excl_a: assert property ((dma_read & dma_write) == 2'b00)
    else $error("read and write together");
  end_write0_a: assert property (transfer_end_n[1:0] != 2'b11 |-> dma_write[0])
    else $error("group 0 end outside write");
  end_write1_a: assert property (transfer_end_n[3:2] != 2'b11 |-> dma_write[1])
    else $error("group 1 end outside write");
  claim_quiet_a: assert property ((irq_flag_clear & cpu_irq) == 8'h00)
    else $error("claimed request reached cpu");
  clear_pulse_a: assert property (irq_flag_clear[0] |=> !irq_flag_clear[0])
    else $error("flag clear not a pulse");
  serial_grp_a: assert property (irq_flag_clear[7:6] != 2'b00 |-> bus_request[1])
    else $error("serial 1 served by wrong group");
  pin_dir_a: assert property (end_pin_output == request_pin_input)
    else $error("pin directions differ");
endmodule
bind dma_activation dma_activation_asserts chk (.clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .cpu_irq, .irq_flag_clear, .transfer_end_n, .request_pin_input, .end_pin_output, .bus_request,
  .bus_grant, .dma_read, .dma_write);

// *** dv/bus_ctrl_model.sv ***
// Bus controller stand-in: grants each group and paces its cycles
`timescale 1ns/10ps
module bus_ctrl_model #(
  parameter int FAST = 0,
  parameter int SLOW = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] bus_request,
  input wire logic [1:0] dma_read,
  input wire logic [1:0] dma_write,
  output logic [1:0] bus_grant,
  output logic [1:0] bus_cycle_done
);
  int cnt [2];
  // Group 1 sees wait states, so slow answers are exercised too
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      bus_grant <= 2'b00;
      bus_cycle_done <= 2'b00;
      cnt <= '{0, 0};
    end
    else
      for (int g = 0; g < 2; g++)
      begin
        bus_grant[g] <= bus_request[g];
        bus_cycle_done[g] <= 1'b0;
        cnt[g] <= 0;
        // No done in the cycle after one, the next cycle must start first
        if ((dma_read[g] || dma_write[g]) && !bus_cycle_done[g])
          if (cnt[g] == (g ? SLOW : FAST))
            bus_cycle_done[g] <= 1'b1;
          else
            cnt[g] <= cnt[g] + 1;
      end
endmodule

// *** dv/dma_activation_tb_top.sv ***
// Self-checking bench for the DMA activation block
`timescale 1ns/10ps
module dma_activation_tb_top;
  import dma_act_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest;
  logic [7:0] irq = 8'h00;
  logic [7:0] cpu_irq, irq_flag_clear, saw_clr, saw_cpu;
  logic [3:0] ext_n = 4'hf;
  logic [3:0] transfer_end_n, request_pin_input, end_pin_output, transfer_end_n_q;
  logic [1:0] bus_request, bus_grant, bus_cycle_done, dma_read, dma_write, req_q;
  logic [1:0] omr = 2'b00;
  logic [2:0] active_channel0, active_channel1, first0, last1;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int wr_cnt [2];
  int rel_cnt [2];
  int transfer_end_n_cnt [4];
  always #5 clk = ~clk;
  dma_activation DUT (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .timer0_match_irq(irq[0]),
    .timer1_match_irq(irq[1]), .timer2_match_irq(irq[2]), .timer3_match_irq(irq[3]),
    .serial0_tx_empty_irq(irq[4]), .serial0_rx_full_irq(irq[5]), .serial1_tx_empty_irq(irq[6]),
    .serial1_rx_full_irq(irq[7]), .cpu_irq, .irq_flag_clear, .ext_transfer_request_n(ext_n),
    .transfer_end_n, .request_pin_input, .end_pin_output, .bus_request, .bus_grant,
    .other_master_request(omr), .bus_cycle_done, .dma_read, .dma_write, .active_channel0, .active_channel1);
  bus_ctrl_model u_bus (.clk, .rst_n, .bus_request, .dma_read, .dma_write, .bus_grant, .bus_cycle_done);
  // Activity monitor; the ceiling is far above the roughly 1500 cycles needed
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    transfer_end_n_q <= transfer_end_n;
    req_q <= bus_request;
    saw_clr <= saw_clr | irq_flag_clear;
    saw_cpu <= saw_cpu | cpu_irq;
    for (int g = 0; g < 2; g++)
    begin
      if (dma_write[g] && bus_cycle_done[g]) wr_cnt[g] <= wr_cnt[g] + 1;
      if (req_q[g] && !bus_request[g]) rel_cnt[g] <= rel_cnt[g] + 1;
    end
    for (int c = 0; c < 4; c++) if (transfer_end_n_q[c] && !transfer_end_n[c]) transfer_end_n_cnt[c] <= transfer_end_n_cnt[c] + 1;
    if (dma_write[0] && wr_cnt[0] == 0) first0 <= active_channel0;
    if (dma_write[1]) last1 <= active_channel1;
    if (cyc > 20000)
    begin
      fails++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One register access, held until a rising edge samples waitrequest low
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Cleared off the clock edge so the monitor never races it
  task automatic clr();
    @(negedge clk);
    wr_cnt = '{0, 0};
    rel_cnt = '{0, 0};
    transfer_end_n_cnt = '{0, 0, 0, 0};
    saw_clr = 8'h00;
    saw_cpu = 8'h00;
  endtask
  task automatic wait_wr(input int g, input int n);
    int k;
    k = 0;
    while (wr_cnt[g] < n && k < 1000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (20) @(posedge clk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    clr();
    chk(transfer_end_n, 4'hf);
    chk(bus_request, 2'b00);
    bus(0, 7'h0c, 32'h0000_0000);
    chk(rdat[7:0], 8'h01);
    bus(0, 7'h44, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    $display("test reset done");
    // Shared timer source on 0A and 0B: A first, both run; the flag drops when cleared
    bus(1, 7'h04, 32'h0000_0001);
    bus(1, 7'h08, 32'h0000_0001);
    bus(1, 7'h00, 32'h0000_0003);
    irq[0] <= 1'b1;
    wait (irq_flag_clear[0]);
    irq[0] <= 1'b0;
    wait_wr(0, 2);
    chk(wr_cnt[0], 2);
    chk(first0, 3'h0);
    chk(saw_clr[0], 1'b1);
    chk(saw_cpu[0], 1'b0);
    chk(transfer_end_n_cnt[0], 2);
    bus(1, 7'h00, 32'h0000_0000);
    $display("test shared irq done");
    // Timer on full normal mode must not start and stays with the cpu
    clr();
    bus(1, 7'h00, 32'h0000_0045);
    irq[1] <= 1'b1;
    wait_wr(0, 1);
    irq[1] <= 1'b0;
    chk(wr_cnt[0], 0);
    chk(saw_cpu[1], 1'b1);
    chk(saw_clr[1], 1'b0);
    bus(1, 7'h00, 32'h0000_0000);
    $display("test illegal source done");
    // Auto-request on channel 1, cycle-steal then burst
    for (int m = 0; m < 2; m++)
    begin
      clr();
      bus(1, 7'h14, 32'h0000_0003);
      bus(1, 7'h10, m ? 32'h0000_01d5 : 32'h0000_01c5);
      wait_wr(0, 3);
      chk(wr_cnt[0], 3);
      chk(transfer_end_n_cnt[1], 1);
      chk(rel_cnt[0], m ? 1 : 3);
      bus(0, 7'h10, 32'h0000_0000);
      chk(rdat[0], 1'b0);
      $display("test auto mode %0d done", m);
    end
    // Request pin on channel 3, edge then level sensing
    for (int m = 0; m < 2; m++)
    begin
      clr();
      bus(1, 7'h34, 32'h0000_0002);
      bus(1, 7'h30, m ? 32'h0000_01a5 : 32'h0000_0185);
      for (int e = 1; e < 3; e++)
      begin
        ext_n[3] <= 1'b0;
        repeat (3) @(posedge clk);
        if (!m) ext_n[3] <= 1'b1;
        wait_wr(1, e);
        chk(wr_cnt[1], m ? 2 : e);
      end
      ext_n[3] <= 1'b1;
      chk(request_pin_input[3], 1'b1);
      chk(transfer_end_n_cnt[3], 1);
      chk(rel_cnt[1], 2);
      chk(last1, 3'h6);
      $display("test pin mode %0d done", m);
    end
    // Serial 1 request serves channel 2A in group 1
    clr();
    bus(1, 7'h24, 32'h0000_0001);
    bus(1, 7'h20, 32'h0000_0101);
    irq[6] <= 1'b1;
    wait (irq_flag_clear[6]);
    irq[6] <= 1'b0;
    wait_wr(1, 1);
    chk(wr_cnt[1], 1);
    chk(saw_clr[6], 1'b1);
    chk(saw_cpu[6], 1'b0);
    chk(last1, 3'h4);
    $display("test serial done");
    results();
  end
endmodule
